//--- pkg/bsr_defs.vh
// constants for the bus reset and standby sequencer
`ifndef BSR_DEFS_VH
`define BSR_DEFS_VH

// ****************************************************************
// widths
// ****************************************************************
`define BSR_ADDR_W      20
`define BSR_DATA_W      8
`define BSR_PORT_W      8
`define BSR_BST_W       3
`define BSR_SEQ_W       3
`define BSR_CNT_W       4

// ****************************************************************
// bus state codes driven by the bus controller
// ****************************************************************
`define BSR_BST_IDLE    3'h0
`define BSR_BST_FIRST   3'h1
`define BSR_BST_SECOND  3'h2
`define BSR_BST_THIRD   3'h3
`define BSR_BST_WAIT    3'h4

// ****************************************************************
// sequencer state codes
// ****************************************************************
`define BSR_SEQ_RUN     3'h0
`define BSR_SEQ_ARMED   3'h1
`define BSR_SEQ_HOLD    3'h2
`define BSR_SEQ_INIT    3'h3
`define BSR_SEQ_SLEEP   3'h4

// ****************************************************************
// timing: system clock is the 200 MHz clock divided by two
// ****************************************************************
`define BSR_RETAIN_CYC  4'hA
`define BSR_CNT_ONE     4'h1
`define BSR_ADDR_ZERO   20'h00000
`define BSR_DATA_ZERO   8'h00
`define BSR_PORT_ZERO   8'h00
`define BSR_PORT_OFF    8'hFF

`endif

//--- design/bsr_phase.v
// system clock phase divider: half-state enable pulses
module bsr_phase
(
	// clock and reset
	input  wire clk,
	input  wire rst,
	// phase enables
	output reg  phi_high,
	output wire phi_fall,
	output wire phi_rise
);

	// ****************************************************************
	// divide by two: each system clock half is one 5 ns cycle
	// ****************************************************************
	always @(posedge clk)
	begin
		if (rst)
			phi_high <= 1'b0;
		else
			phi_high <= ~phi_high;
	end

	// falling edge pulse comes in the cycle where the phase is high
	assign phi_fall = phi_high;
	assign phi_rise = ~phi_high;

endmodule // bsr_phase

//--- design/bsr_top.v
// bus pin reset sequencer and hardware standby handling
`include "bsr_defs.vh"

module bsr_top
(
	// clock and reset
	input  wire                     clk,
	input  wire                     rst,
	// board control pins
	input  wire                     chip_init_n,
	input  wire                     hold_low_power_n,
	input  wire                     internal_ram_enable,
	// bus controller side
	input  wire [`BSR_BST_W-1:0]    bus_state,
	input  wire                     two_state_area,
	input  wire [`BSR_ADDR_W-1:0]   core_addr,
	input  wire                     core_as_n,
	input  wire                     core_rd_n,
	input  wire                     core_wr_n,
	input  wire [`BSR_DATA_W-1:0]   core_data,
	input  wire                     core_data_drive,
	// general port side
	input  wire [`BSR_PORT_W-1:0]   core_port_out,
	input  wire [`BSR_PORT_W-1:0]   core_port_dir,
	// address pins
	output wire [`BSR_ADDR_W-1:0]   addr_out,
	output wire                     addr_oe_n,
	// strobe pins
	output wire                     address_strobe_n,
	output wire                     read_strobe_n,
	output wire                     store_strobe_n,
	output wire                     strobe_oe_n,
	// data pins
	output wire [`BSR_DATA_W-1:0]   data_out,
	output wire                     data_oe_n,
	// port pins
	output wire [`BSR_PORT_W-1:0]   port_out,
	output wire [`BSR_PORT_W-1:0]   port_oe_n,
	// status
	output wire                     init_active,
	output wire                     standby_active,
	output reg                      retain_fault
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	wire                    phi_fall;
	wire                    phi_rise;
	reg  [`BSR_SEQ_W-1:0]   seq;
	reg  [`BSR_SEQ_W-1:0]   next_seq;
	reg  [`BSR_ADDR_W-1:0]  addr_q;
	reg  [`BSR_DATA_W-1:0]  data_q;
	reg  [`BSR_PORT_W-1:0]  port_q;
	reg  [`BSR_CNT_W-1:0]   init_cnt;
	reg                     standby_prev;
	wire                    init_now;
	wire                    in_standby;
	wire                    holds_addr;
	wire                    clears_addr;
	wire                    sample_low;
	wire                    sample_high;

	// ****************************************************************
	// system clock phases
	// ****************************************************************
	bsr_phase u_phase
	(
		.clk      (clk),
		.rst      (rst),
		.phi_high (),
		.phi_fall (phi_fall),
		.phi_rise (phi_rise)
	);

	// ****************************************************************
	// pin level decode
	// ****************************************************************
	// the pin acts at once on the strobe, data and port pins, the sequencer only on samples except on leaving standby
	assign init_now    = ~chip_init_n;
	assign in_standby  = ~hold_low_power_n;
	assign sample_low  = phi_fall & ~chip_init_n;
	assign sample_high = phi_fall &  chip_init_n;

	// states in which the address is still valid and must be held
	assign holds_addr  = (bus_state == `BSR_BST_THIRD) |
	                     (two_state_area &
	                      (bus_state == `BSR_BST_SECOND));

	// states whose address is dropped half a state after sampling
	assign clears_addr = ~holds_addr &
	                     ((bus_state == `BSR_BST_FIRST) |
	                      (bus_state == `BSR_BST_SECOND) |
	                      (bus_state == `BSR_BST_WAIT));

	// ****************************************************************
	// sequencer next state
	// ****************************************************************
	always @*
	begin
		next_seq = seq;
		case (seq)
			`BSR_SEQ_RUN:
			begin
				if (in_standby)
					next_seq = `BSR_SEQ_SLEEP;
				else if (sample_low && holds_addr)
					next_seq = `BSR_SEQ_HOLD;
				else if (sample_low && clears_addr)
					next_seq = `BSR_SEQ_ARMED;
				else if (sample_low)
					next_seq = `BSR_SEQ_INIT;
			end
			`BSR_SEQ_ARMED:
			begin
				// half a state after the falling-edge sample
				if (in_standby)
					next_seq = `BSR_SEQ_SLEEP;
				else if (phi_rise)
					next_seq = `BSR_SEQ_INIT;
			end
			`BSR_SEQ_HOLD:
			begin
				// the held state ends at the next falling edge
				if (in_standby)
					next_seq = `BSR_SEQ_SLEEP;
				else if (phi_fall)
					next_seq = `BSR_SEQ_INIT;
			end
			`BSR_SEQ_INIT:
			begin
				if (in_standby)
					next_seq = `BSR_SEQ_SLEEP;
				else if (sample_high)
					next_seq = `BSR_SEQ_RUN;
			end
			`BSR_SEQ_SLEEP:
			begin
				// leave into the reset state while the reset pin is low,
				// or straight back to run once the pin is already high
				if (!in_standby && init_now)
					next_seq = `BSR_SEQ_INIT;
				else if (!in_standby)
					next_seq = `BSR_SEQ_RUN;
			end
			default:
				next_seq = `BSR_SEQ_INIT;
		endcase
	end

	// ****************************************************************
	// sequencer state register
	// ****************************************************************
	always @(posedge clk)
	begin
		if (rst)
			seq <= `BSR_SEQ_INIT;
		else
			seq <= next_seq;
	end

	// ****************************************************************
	// address register
	// ****************************************************************
	// outside reset and standby the address follows the bus controller; a held
	// address freezes, an initialised one reads as all zero
	always @(posedge clk)
	begin
		if (rst)
			addr_q <= `BSR_ADDR_ZERO;
		else if (next_seq == `BSR_SEQ_INIT)
			addr_q <= `BSR_ADDR_ZERO;
		else if (next_seq == `BSR_SEQ_HOLD ||
		         next_seq == `BSR_SEQ_ARMED)
			addr_q <= addr_q;
		else if (next_seq == `BSR_SEQ_RUN && !init_now)
			addr_q <= core_addr;
	end

	// ****************************************************************
	// data and port output registers
	// ****************************************************************
	always @(posedge clk)
	begin
		if (rst)
		begin
			data_q <= `BSR_DATA_ZERO;
			port_q <= `BSR_PORT_ZERO;
		end
		else
		begin
			data_q <= core_data;
			port_q <= core_port_out;
		end
	end

	// ****************************************************************
	// retention check on the board sequence
	// ****************************************************************
	// counts system cycles the reset pin has been low; saturates so
	// a long reset never wraps back under the threshold
	always @(posedge clk)
	begin
		if (rst || !chip_init_n)
		begin
			if (rst || chip_init_n)
				init_cnt <= {`BSR_CNT_W{1'b0}};
			else if (phi_fall && init_cnt != `BSR_RETAIN_CYC)
				init_cnt <= init_cnt + `BSR_CNT_ONE;
		end
		else
			init_cnt <= {`BSR_CNT_W{1'b0}};
	end

	// the far side owes this order; we only flag a breach
	always @(posedge clk)
	begin
		if (rst)
		begin
			standby_prev <= 1'b1;
			retain_fault <= 1'b0;
		end
		else
		begin
			standby_prev <= hold_low_power_n;
			if (standby_prev && !hold_low_power_n && internal_ram_enable &&
			    init_cnt != `BSR_RETAIN_CYC)
				retain_fault <= 1'b1;
		end
	end

	// ****************************************************************
	// address pins
	// ****************************************************************
	// a held or armed address keeps driving; standby floats it
	assign addr_out  = addr_q;
	assign addr_oe_n = in_standby | (seq == `BSR_SEQ_SLEEP);

	// ****************************************************************
	// strobe pins
	// ****************************************************************
	// combinational override: the strobes must rise in the same
	// cycle as the pin, not one sample later
	assign address_strobe_n = core_as_n | init_now |
	                          (seq != `BSR_SEQ_RUN);
	assign read_strobe_n    = core_rd_n | init_now |
	                          (seq != `BSR_SEQ_RUN);
	assign store_strobe_n   = core_wr_n | init_now |
	                          (seq != `BSR_SEQ_RUN);
	assign strobe_oe_n      = addr_oe_n;

	// ****************************************************************
	// data pins
	// ****************************************************************
	assign data_out  = data_q;
	assign data_oe_n = ~core_data_drive | init_now | in_standby |
	                   (seq != `BSR_SEQ_RUN);

	// ****************************************************************
	// port pins
	// ****************************************************************
	// every port turns input while reset or standby is present
	assign port_out  = port_q;
	assign port_oe_n = (init_now | in_standby | (seq != `BSR_SEQ_RUN)) ?
	                   `BSR_PORT_OFF : ~core_port_dir;

	// ****************************************************************
	// status
	// ****************************************************************
	assign init_active    = init_now | (seq != `BSR_SEQ_RUN);
	assign standby_active = (seq == `BSR_SEQ_SLEEP);

endmodule // bsr_top

//--- dv/bsr_monitor.sv
// assertion checker for the bus reset and standby sequencer
`include "bsr_defs.vh"
module bsr_monitor
(
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// board and bus inputs
	input wire logic        chip_init_n,
	input wire logic        hold_low_power_n,
	input wire logic [2:0]  bus_state,
	input wire logic        two_state_area,
	// pin outputs and status
	input wire logic [19:0] addr_out,
	input wire logic        addr_oe_n,
	input wire logic        address_strobe_n,
	input wire logic        read_strobe_n,
	input wire logic        store_strobe_n,
	input wire logic        strobe_oe_n,
	input wire logic        data_oe_n,
	input wire logic [7:0]  port_oe_n,
	input wire logic        init_active,
	input wire logic        standby_active,
	input wire logic        retain_fault
);
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// properties
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// running cycle meets reset that stays low long enough to act
	sequence s_hit(ok);
		chip_init_n && !init_active && hold_low_power_n && ok
		##1 (!chip_init_n && hold_low_power_n && ok) [*4];
	endsequence
	// only three edges: a held address must not yet be cleared
	sequence s_held(ok);
		chip_init_n && !init_active && hold_low_power_n && ok
		&& addr_out != 20'h00000
		##1 (!chip_init_n && hold_low_power_n && ok) [*3];
	endsequence
	property p_ports_in;
		!chip_init_n |-> port_oe_n == 8'hFF;
	endproperty
	a_ports_in: assert property (p_ports_in) else $error("ports driven");
	property p_strobes;
		!chip_init_n |-> address_strobe_n && read_strobe_n
			&& store_strobe_n && data_oe_n;
	endproperty
	a_strobes: assert property (p_strobes) else $error("strobe low");
	property p_early;
		s_hit(bus_state == 3'h1 || (bus_state == 3'h2 && !two_state_area))
		|-> addr_out == 20'h00000;
	endproperty
	a_early: assert property (p_early) else $error("addr not low");
	property p_wait;
		s_hit(bus_state == 3'h4 && !two_state_area) |-> addr_out == 20'h00000;
	endproperty
	a_wait: assert property (p_wait) else $error("wait addr not low");
	property p_third;
		s_held(bus_state == 3'h3) |-> addr_out != 20'h00000;
	endproperty
	a_third: assert property (p_third) else $error("addr not held");
	property p_two;
		s_held(bus_state == 3'h2 && two_state_area) |-> addr_out != 20'h00000;
	endproperty
	a_two: assert property (p_two) else $error("two-state not held");
	property p_sample;
		$rose(chip_init_n) ##1 (chip_init_n && hold_low_power_n) [*3]
		|-> !init_active;
	endproperty
	a_sample: assert property (p_sample) else $error("init stuck");
	property p_standby_float;
		!hold_low_power_n |-> addr_oe_n && strobe_oe_n && data_oe_n
			&& port_oe_n == 8'hFF;
	endproperty
	a_standby_float: assert property (p_standby_float)
		else $error("drives");
	property p_standby_state;
		!hold_low_power_n |=> standby_active;
	endproperty
	a_standby_state: assert property (p_standby_state)
		else $error("no standby");
	// fault flag must survive until the next reset
	property p_fault_keep;
		retain_fault |=> retain_fault;
	endproperty
	a_fault_keep: assert property (p_fault_keep) else $error("fault lost");
endmodule // bsr_monitor

bind bsr_top bsr_monitor i_bsr_monitor (.clk(clk), .rst(rst),
	.chip_init_n(chip_init_n), .hold_low_power_n(hold_low_power_n),
	.bus_state(bus_state), .two_state_area(two_state_area),
	.addr_out(addr_out), .addr_oe_n(addr_oe_n),
	.address_strobe_n(address_strobe_n), .read_strobe_n(read_strobe_n),
	.store_strobe_n(store_strobe_n), .strobe_oe_n(strobe_oe_n),
	.data_oe_n(data_oe_n), .port_oe_n(port_oe_n),
	.init_active(init_active), .standby_active(standby_active),
	.retain_fault(retain_fault));

//--- dv/bsr_board.sv
// board model driving the reset, standby and ram enable pins
module bsr_board
(
	// clock
	input wire logic clk,
	// board pins
	output logic     chip_init_n,
	output logic     hold_low_power_n,
	output logic     internal_ram_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// pin sequencing
	// ************************************************************
	initial
	begin
		chip_init_n = 1'b1;
		hold_low_power_n = 1'b1;
		internal_ram_enable = 1'b1;
	end
	// pins move on the falling edge, clear of the sampling edge
	task automatic set_pins(input logic init_n, input logic standby_n);
	begin
		@(negedge clk);
		chip_init_n = init_n;
		hold_low_power_n = standby_n;
	end
	endtask
	// lead counts system cycles; a short lead is a deliberate fault
	task automatic enter_standby(input logic ram, input int lead);
	begin
		internal_ram_enable = ram;
		if (ram)
			set_pins(1'b0, 1'b1);
		repeat (2 * lead) @(negedge clk);
		set_pins(!ram, 1'b0);
		set_pins(1'b1, 1'b0);
	end
	endtask
	// 20 clocks of 5 ns give the 100 ns lead before waking
	task automatic leave_standby();
	begin
		set_pins(1'b0, 1'b0);
		repeat (20) @(negedge clk);
		set_pins(1'b0, 1'b1);
	end
	endtask
endmodule // bsr_board

//--- dv/tb_bsr_top.sv
// self-checking testbench for the bus reset and standby sequencer
module tb_bsr_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// signals
	// ************************************************************
	logic clk, rst, chip_init_n, hold_low_power_n, internal_ram_enable;
	logic [2:0] bus_state;
	logic [19:0] core_addr, addr_out;
	logic [7:0] core_data, core_port_out, core_port_dir, data_out;
	logic [7:0] port_out, port_oe_n;
	logic two_state_area, core_as_n, core_rd_n, core_wr_n;
	logic core_data_drive, addr_oe_n, address_strobe_n, read_strobe_n;
	logic store_strobe_n, strobe_oe_n, data_oe_n, init_active;
	logic standby_active, retain_fault;
	int n_mismatch = 0;
	int n_checks = 0;
	int cycles = 0;
	bsr_board i_bsr_board (.clk(clk), .chip_init_n(chip_init_n),
		.hold_low_power_n(hold_low_power_n),
		.internal_ram_enable(internal_ram_enable));
	bsr_top i_bsr_top (.clk(clk), .rst(rst), .chip_init_n(chip_init_n),
		.hold_low_power_n(hold_low_power_n),
		.internal_ram_enable(internal_ram_enable), .bus_state(bus_state),
		.two_state_area(two_state_area), .core_addr(core_addr),
		.core_as_n(core_as_n), .core_rd_n(core_rd_n), .core_wr_n(core_wr_n),
		.core_data(core_data), .core_data_drive(core_data_drive),
		.core_port_out(core_port_out), .core_port_dir(core_port_dir),
		.addr_out(addr_out), .addr_oe_n(addr_oe_n),
		.address_strobe_n(address_strobe_n), .read_strobe_n(read_strobe_n),
		.store_strobe_n(store_strobe_n), .strobe_oe_n(strobe_oe_n),
		.data_out(data_out), .data_oe_n(data_oe_n), .port_out(port_out),
		.port_oe_n(port_oe_n), .init_active(init_active),
		.standby_active(standby_active), .retain_fault(retain_fault));
	// ************************************************************
	// tasks
	// ************************************************************
	task automatic print_verdict();
	begin
		if (n_mismatch == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
	begin
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	end
	endtask
	// bounded wait for the sequencer to leave reset handling
	task automatic wait_run();
	begin
		repeat (24)
			if (init_active !== 1'b0)
				@(negedge clk);
		check("init_active", init_active, 0);
	end
	endtask
	// reset met in bus state st; hold selects the held-address outcome
	task automatic bus_reset(input logic [2:0] st, input logic two,
		input logic hold);
	begin
		bus_state = st;
		two_state_area = two;
		wait_run();
		@(negedge clk);
		check("drive", {addr_oe_n, strobe_oe_n, port_oe_n,
			address_strobe_n, read_strobe_n, store_strobe_n,
			data_oe_n}, 0);
		check("data_out", data_out, 8'h96);
		check("port_out", port_out, 8'h5A);
		i_bsr_board.set_pins(1'b0, 1'b1);
		#1;
		check("port_oe_n", port_oe_n, 8'hFF);
		check("strobes", {address_strobe_n, read_strobe_n,
			store_strobe_n, data_oe_n}, 4'hF);
		@(negedge clk);
		check("addr_out", addr_out, core_addr);
		@(negedge clk);
		if (hold)
			check("addr_out", addr_out, core_addr);
		@(negedge clk);
		if (!hold)
			check("addr_out", addr_out, 0);
		repeat (3) @(negedge clk);
		check("addr_out", addr_out, 0);
		i_bsr_board.set_pins(1'b1, 1'b1);
		wait_run();
		@(negedge clk);
		check("addr_out", addr_out, core_addr);
	end
	endtask
	// standby round trip; fault is the expected ordering flag
	task automatic standby(input logic ram, input int lead,
		input logic fault);
	begin
		i_bsr_board.enter_standby(ram, lead);
		@(negedge clk);
		check("standby_active", standby_active, 1);
		check("oe_n", {addr_oe_n, strobe_oe_n, data_oe_n, port_oe_n},
			11'h7FF);
		check("retain_fault", retain_fault, fault);
		i_bsr_board.leave_standby();
		#1;
		check("init_active", init_active, 1);
		// standby over with reset still low: back in reset handling
		@(negedge clk);
		check("standby_active", standby_active, 0);
		check("addr", {addr_oe_n, addr_out}, 0);
		i_bsr_board.set_pins(1'b1, 1'b1);
		wait_run();
	end
	endtask
	// ************************************************************
	// clock, timeout and main sequence
	// ************************************************************
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// a hang counts as a mismatch
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			n_mismatch++;
			print_verdict();
		end
	end
	initial
	begin
		rst = 1'b1;
		bus_state = 3'h0;
		two_state_area = 1'b0;
		core_addr = 20'hA5C3E;
		{core_as_n, core_rd_n, core_wr_n} = 3'h0;
		core_data = 8'h96;
		core_data_drive = 1'b1;
		core_port_out = 8'h5A;
		core_port_dir = 8'hFF;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		bus_reset(3'h1, 1'b0, 1'b0);
		bus_reset(3'h2, 1'b0, 1'b0);
		bus_reset(3'h4, 1'b0, 1'b0);
		bus_reset(3'h3, 1'b0, 1'b1);
		bus_reset(3'h2, 1'b1, 1'b1);
		standby(1'b1, 10, 1'b0);
		standby(1'b0, 0, 1'b0);
		standby(1'b1, 2, 1'b1);
		print_verdict();
	end
endmodule // tb_bsr_top
